// [shared/smcp_map.vh]
// constants for the storage media command parser
`ifndef SMCP_MAP_VH
`define SMCP_MAP_VH

// message kinds
`define SMCP_KIND_CTRL 8'h01
`define SMCP_KIND_ACK 8'h02

// selection purpose codes
`define SMCP_SELM_STORE 5'h01
`define SMCP_SELM_RETR 5'h02

// field lengths in bits
`define SMCP_LEN_KIND 6'd8
`define SMCP_LEN_CTRL 6'd16
`define SMCP_LEN_SEL 6'd40
`define SMCP_LEN_RET 6'd16
`define SMCP_LEN_OPT 6'd8
`define SMCP_LEN_STO 6'd8
`define SMCP_LEN_TCH 6'd8
`define SMCP_LEN_TCB 6'd40
`define SMCP_ACK_BITS 7'd72
`define SMCP_ACK_BITS_SHORT 7'd24

// acknowledgement type bits
`define SMCP_ACK_SEL 4'h8
`define SMCP_ACK_RET 4'h4
`define SMCP_ACK_STO 4'h2
`define SMCP_ACK_ERR 4'h1

// timing
`define SMCP_SYS_CLK_HZ 40000000
`define SMCP_TC_CLK_HZ 90000
`define SMCP_TC_TICK_CYC (`SMCP_SYS_CLK_HZ / `SMCP_TC_CLK_HZ)
`define SMCP_FAST_STEP 33'd4

// register byte offsets
`define SMCP_REG_CTRL 8'h00
`define SMCP_REG_STATUS 8'h04
`define SMCP_REG_STREAM 8'h08
`define SMCP_REG_PTS_LO 8'h0C
`define SMCP_REG_PTS_HI 8'h10
`define SMCP_REG_REMAIN 8'h14
`define SMCP_REG_COUNT 8'h18

// control register fields and reset
`define SMCP_CTRL_PARSE_EN 0
`define SMCP_CTRL_ACK_EN 1
`define SMCP_CTRL_RESET 2'h3

`endif

// [test/smcp_initiator.sv]
// command initiator model: serial command source and ack sink
`timescale 1ns/1ps
`default_nettype none
module smcp_initiator (
  input wire logic clock_i,
  input wire logic slow_i,
  output logic frame_start_o,
  output logic cmd_bit_o,
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  input wire logic ack_bit_i,
  input wire logic ack_valid_i,
  input wire logic ack_last_i,
  output logic ack_ready_o
);
  logic [71:0] shift_r;
  logic [71:0] ack_word;
  logic [6:0] bits_r;
  logic [6:0] ack_len;
  int ack_cnt;
  logic stuck;
  initial begin
    frame_start_o = 1'b0;
    cmd_bit_o = 1'b0;
    cmd_valid_o = 1'b0;
    ack_ready_o = 1'b0;
    shift_r = 72'h0;
    ack_word = 72'h0;
    bits_r = 7'h00;
    ack_len = 7'h00;
    ack_cnt = 0;
    stuck = 1'b0;
  end
  task automatic send(input logic [199:0] m, input int n);
    int i;
    int w;
    @(posedge clock_i);
    frame_start_o <= 1'b1;
    @(posedge clock_i);
    frame_start_o <= 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      cmd_bit_o <= m[i];
      cmd_valid_o <= 1'b1;
      w = 0;
      do begin
        @(posedge clock_i);
        w++;
      end while (cmd_ready_i !== 1'b1 && w < 500);
      if (w >= 500) begin
        stuck = 1'b1;
      end
    end
    cmd_valid_o <= 1'b0;
    cmd_bit_o <= ~m[0];
  endtask
  // ack sink, stalls every other cycle when slow
  always @(posedge clock_i) begin
    ack_ready_o <= slow_i ? ~ack_ready_o : 1'b1;
    if (ack_valid_i && ack_ready_o) begin
      shift_r <= ack_last_i ? 72'h0 : {shift_r[70:0], ack_bit_i};
      bits_r <= ack_last_i ? 7'h00 : bits_r + 7'h01;
      if (ack_last_i) begin
        ack_word <= {shift_r[70:0], ack_bit_i};
        ack_len <= bits_r + 7'h01;
        ack_cnt <= ack_cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [test/smcp_parser_assertions.sv]
// port checker for the storage media command parser
`timescale 1ns/1ps
`default_nettype none
module smcp_parser_assertions #(
  parameter TICK_CYC = 4
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic cmd_ready_o,
  input wire logic ack_bit_o,
  input wire logic ack_valid_o,
  input wire logic ack_last_o,
  input wire logic ack_ready_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  logic [6:0] pos_r;
  logic [3:0] typ_r;
  logic stat_r;
  wire take = ack_valid_o && ack_ready_i;
  // bit position inside the ack being sent
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      pos_r <= 7'h00;
      typ_r <= 4'h0;
      stat_r <= 1'b0;
    end else if (take) begin
      pos_r <= ack_last_o ? 7'h00 : pos_r + 7'h01;
      if (pos_r >= 7'h08 && pos_r < 7'h0C) begin
        typ_r <= {typ_r[2:0], ack_bit_o};
      end
      if (pos_r == 7'h17) begin
        stat_r <= ack_bit_o;
      end
    end
  end
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  hole_zero_a: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h18 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  ack_hold_a: assert property (
    ack_valid_o && !ack_ready_i |=> ack_valid_o && $stable(ack_bit_o) && $stable(ack_last_o))
    else $error("ack bit not held");
  kind_bits_a: assert property (take && pos_r < 7'h08 |-> ack_bit_o == (pos_r == 7'h06))
    else $error("ack kind wrong");
  resv_zero_a: assert property (
    take && (pos_r inside {[7'd12:7'd21], [7'd24:7'd35]}) |-> !ack_bit_o)
    else $error("ack reserved bit set");
  marker_one_a: assert property (
    take && (pos_r inside {7'd22, 7'd39, 7'd55, 7'd71}) |-> ack_bit_o)
    else $error("ack marker clear");
  one_type_a: assert property (take && pos_r == 7'h0C |-> $onehot(typ_r))
    else $error("ack type not onehot");
  ack_end_a: assert property (take && ack_last_o |-> pos_r == 7'h17 || pos_r == 7'h47)
    else $error("ack length wrong");
  long_only_a: assert property (take && pos_r == 7'h18 |-> stat_r && (typ_r[2] || typ_r[1]))
    else $error("time code on wrong ack");
  rst_quiet_a: assert property (disable iff (1'b0)
    !nrst_i |=> !cmd_ready_o && !ack_valid_o && !wb_ack_o)
    else $error("outputs active in reset");
endmodule
`default_nettype wire

// [test/smcp_parser_tb.sv]
// self-checking bench for the storage media command parser
`timescale 1ns/1ps
`default_nettype none
`include "smcp_map.vh"
module smcp_parser_tb;
  localparam int TICK = 4;
  localparam logic [31:0] ID = 32'hA5C3_0F96;
  logic clock_i, nrst_i, slow, frame_start_i, cmd_bit_i, cmd_valid_i, ack_ready_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, rd;
  logic [3:0] wb_sel_i;
  wire cmd_ready_o, ack_bit_o, ack_valid_o, ack_last_o, wb_ack_o;
  wire [31:0] wb_dat_o;
  logic [199:0] m;
  int n, seen, i, fail_count, comparisons;
  smcp_parser #(.TICK_CYC(TICK)) u_smcp_parser (.clock_i, .nrst_i, .frame_start_i,
    .cmd_bit_i, .cmd_valid_i, .cmd_ready_o, .ack_bit_o, .ack_valid_o, .ack_last_o,
    .ack_ready_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o);
  smcp_initiator u_smcp_initiator (.clock_i, .slow_i(slow), .frame_start_o(frame_start_i),
    .cmd_bit_o(cmd_bit_i), .cmd_valid_o(cmd_valid_i), .cmd_ready_i(cmd_ready_o),
    .ack_bit_i(ack_bit_o), .ack_valid_i(ack_valid_o), .ack_last_i(ack_last_o),
    .ack_ready_o(ack_ready_i));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    close_out();
  end
  task automatic chk(input string nm, input logic [78:0] e, input logic [78:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int w;
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    w = 0;
    do begin
      @(posedge clock_i);
      w++;
    end while (wb_ack_o !== 1'b1 && w < 50);
    rd = wb_dat_o;
    chk("bus ack", 1'b1, wb_ack_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic put(input logic [47:0] v, input int w);
    m = (m << w) | (v & ((48'h1 << w) - 48'h1));
    n += w;
  endtask
  task automatic cmd(input logic [2:0] ops);
    m = 0;
    n = 0;
    put(`SMCP_KIND_CTRL, 8);
    put({ops, 12'h000, 1'b1}, 16);
  endtask
  task automatic ret(input logic [4:0] rq);
    cmd(3'b010);
    put({rq, 10'h000, 1'b1}, 16);
  endtask
  function automatic logic [47:0] tc(input logic [32:0] t);
    return {12'h000, t[32:30], 1'b1, t[29:15], 1'b1, t[14:0], 1'b1};
  endfunction
  function automatic logic [23:0] ak(input logic [3:0] ty, input logic st);
    return {`SMCP_KIND_ACK, ty, 10'h000, 1'b1, st};
  endfunction
  task automatic go();
    u_smcp_initiator.send(m, n);
  endtask
  task automatic expect_ack(input logic [6:0] l, input logic [71:0] w, input int s);
    int t;
    t = 0;
    while (u_smcp_initiator.ack_cnt == seen && t < 3000) begin
      @(posedge clock_i);
      t++;
    end
    chk("ack wait", 1'b1, t < 3000);
    seen = u_smcp_initiator.ack_cnt;
    chk("ack", {l, w}, {u_smcp_initiator.ack_len, u_smcp_initiator.ack_word >> s});
  endtask
  task automatic sel(input logic [4:0] md, input logic st);
    cmd(3'b100);
    put({ID[31:17], 1'b1, ID[16:2], 1'b1}, 32);
    put({ID[1:0], md, 1'b1}, 8);
    go();
    expect_ack(7'd24, ak(`SMCP_ACK_SEL, st), 0);
  endtask
  task automatic state(input logic [4:0] e);
    wb(1'b0, `SMCP_REG_STATUS, 32'h0);
    chk("state", e, rd[4:0]);
  endtask
  initial begin
    nrst_i = 1'b0;
    slow = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    m = 0;
    n = 0;
    seen = 0;
    fail_count = 0;
    comparisons = 0;
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    wb(1'b1, `SMCP_REG_CTRL, 32'h3);
    wb(1'b0, `SMCP_REG_CTRL, 32'h0);
    chk("ctrl", `SMCP_CTRL_RESET, rd);
    state(5'h01);
    wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h1C, 32'h0);
    chk("hole", 32'h0, rd);
    m = 0;
    n = 0;
    put(8'h03, 8);
    go();
    cmd(3'b000);
    go();
    ret(5'b00000);
    go();
    cmd(3'b001);
    put(8'h00, 8);
    go();
    repeat (10) @(posedge clock_i);
    chk("ignored", seen, u_smcp_initiator.ack_cnt);
    cmd(3'b110);
    go();
    expect_ack(7'd24, ak(`SMCP_ACK_SEL, 1'b0), 0);
    sel(5'h00, 1'b0);
    sel(`SMCP_SELM_RETR, 1'b1);
    wb(1'b0, `SMCP_REG_STREAM, 32'h0);
    chk("stream", ID, rd);
    wb(1'b0, `SMCP_REG_STATUS, 32'h0);
    chk("status", {5'h02, 5'h02}, {rd[20:16], rd[4:0]});
    ret(5'b00101);
    go();
    expect_ack(7'd24, ak(`SMCP_ACK_RET, 1'b0), 0);
    for (i = 0; i < 2; i++) begin
      ret(i ? 5'b00010 : 5'b00100);
      go();
      expect_ack(7'd24, ak(`SMCP_ACK_RET, 1'b0), 0);
    end
    slow <= 1'b1;
    ret(5'b10000);
    put(8'h01, 8);
    put(tc(33'd100), 48);
    go();
    expect_ack(7'd72, {ak(`SMCP_ACK_RET, 1'b1), tc(33'd100)}, 0);
    ret(5'b01000);
    put(8'hC0, 8);
    put(tc(33'd200), 48);
    go();
    expect_ack(7'd72, {ak(`SMCP_ACK_RET, 1'b1), tc(33'd100)}, 0);
    state(5'h04);
    ret(5'b10000);
    put(8'h01, 8);
    put(tc(33'd5), 48);
    go();
    expect_ack(7'd24, ak(`SMCP_ACK_RET, 1'b0), 0);
    expect_ack(7'd72, {ak(`SMCP_ACK_RET, 1'b1), tc(33'd300)}, 0);
    cmd(3'b001);
    put(8'h02, 8);
    put(8'h01, 8);
    go();
    expect_ack(7'd24, ak(`SMCP_ACK_STO, 1'b0), 0);
    sel(`SMCP_SELM_STORE, 1'b1);
    cmd(3'b001);
    put(8'h02, 8);
    put(8'h01, 8);
    go();
    expect_ack(7'd72, {ak(`SMCP_ACK_STO, 1'b1), tc(33'd0)}, 0);
    state(5'h10);
    cmd(3'b001);
    put(8'h01, 8);
    go();
    expect_ack(7'd72, ak(`SMCP_ACK_STO, 1'b1), 48);
    state(5'h02);
    sel(`SMCP_SELM_RETR, 1'b1);
    for (i = 0; i < 2; i++) begin
      ret(5'b01000);
      put(i ? 8'h00 : 8'h40, 8);
      put(tc(i ? 33'd40 : 33'd10), 48);
      go();
      expect_ack(7'd72, {ak(`SMCP_ACK_RET, 1'b1), tc(i ? 33'd12 : 33'd0)}, 0);
      expect_ack(i ? 7'd24 : 7'd72, i ? {48'h0, ak(`SMCP_ACK_ERR, 1'b0)} :
                 {ak(`SMCP_ACK_RET, 1'b1), tc(33'd12)}, 0);
    end
    chk("stall", 1'b0, u_smcp_initiator.stuck);
    close_out();
  end
endmodule
bind smcp_parser smcp_parser_assertions #(.TICK_CYC(TICK_CYC)) u_chk (.clock_i, .nrst_i,
  .cmd_ready_o, .ack_bit_o, .ack_valid_o, .ack_last_o, .ack_ready_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o);
`default_nettype wire

// [verilog/smcp_parser.v]
// storage media command parser and acknowledgement builder
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "smcp_map.vh"

// Operation
// - one operation bit; none means ignore
// - one retrieval request; none means ignore
// - capture or halt; none means ignore
// - control word: three op bits, reserved, marker
// - marker bits always one
// - reserved bits sent as zero
// - selection fields: id pieces, purpose, markers
// - join id pieces into 32-bit stream number
// - purpose: 1 storage, 2 retrieval, else invalid
// - retrieval word: five requests, reserved, marker
// - seek: reserved, direction, time code
// - seek moves pointer, only while stopped
// - timed play: speed, direction, reserved, time code
// - timed play from current timestamp, commanded parameters; a play while playing keeps the running speed, direction and duration
// - pause halts, pointer kept
// - resume forward normal, only when paused
// - halt stops stream transmission
// - direction one forward, zero backward
// - speed one normal, zero fast
// - capture records until duration or halt
// - ack sets exactly one type bit
// - ack word layout; time code when retrieval or storage accepted
// - time codes count 90 kHz cycles
// - time code: flag, then 33-bit timestamp
// - kind 0x01 command, 0x02 acknowledgement
// - status one accepted, zero rejected
module smcp_parser #(
  parameter TICK_CYC = `SMCP_TC_TICK_CYC
) (
  input wire clock_i,
  input wire nrst_i,
  input wire frame_start_i,
  input wire cmd_bit_i,
  input wire cmd_valid_i,
  output reg cmd_ready_o,
  output reg ack_bit_o,
  output reg ack_valid_o,
  output reg ack_last_o,
  input wire ack_ready_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o
);

  // parser states
  localparam P_KIND = 10'h001;
  localparam P_CTRL = 10'h002;
  localparam P_SEL = 10'h004;
  localparam P_RET = 10'h008;
  localparam P_OPT = 10'h010;
  localparam P_STO = 10'h020;
  localparam P_TCH = 10'h040;
  localparam P_TCB = 10'h080;
  localparam P_EXEC = 10'h100;
  localparam P_SKIP = 10'h200;

  // stream states
  localparam S_NONE = 5'h01;
  localparam S_STOP = 5'h02;
  localparam S_PLAY = 5'h04;
  localparam S_PAUSE = 5'h08;
  localparam S_REC = 5'h10;

  reg [9:0] pst_r;
  reg [5:0] cnt_r;
  reg [39:0] sh_r;
  reg op_sel_r;
  reg op_ret_r;
  reg op_sto_r;
  reg [4:0] req_r;
  reg rec_r;
  reg halt_r;
  reg bad_r;
  reg dir_r;
  reg speed_r;
  reg inf_r;
  reg [32:0] tcv_r;
  reg [31:0] id_r;
  reg [4:0] selm_r;

  reg [4:0] sst_r;
  reg [4:0] mode_r;
  reg [31:0] stream_number_r;
  reg [32:0] pts_r;
  reg [32:0] remain_r;
  reg run_inf_r;
  reg run_dir_r;
  reg run_fast_r;
  reg [8:0] tick_cnt_r;
  reg tick_r;
  reg pend_r;
  reg [3:0] pend_type_r;
  reg pend_stat_r;

  reg [71:0] tx_sh_r;
  reg [6:0] tx_len_r;
  reg [1:0] ctrl_r;
  reg last_stat_r;
  reg [3:0] last_type_r;
  reg [15:0] n_acc_r;
  reg [15:0] n_rej_r;

  wire [39:0] sh_nxt = {sh_r[38:0], cmd_bit_i};
  wire take = cmd_valid_i & cmd_ready_o;
  wire seg_end = take & (cnt_r == 6'd1);
  wire tx_idle = (tx_len_r == 7'd0);
  wire [2:0] ops = sh_nxt[15:13];
  wire [4:0] reqs = sh_nxt[15:11];
  wire tx_go = tx_idle & ctrl_r[`SMCP_CTRL_ACK_EN];

  // execution outcome
  reg ex_stat;
  reg [3:0] ex_type;
  reg ex_send;
  reg [4:0] ex_sst;
  reg [32:0] ex_pts;

  always @* begin
    ex_stat = 1'b0;
    ex_type = `SMCP_ACK_ERR;
    ex_send = 1'b1;
    ex_sst = sst_r;
    ex_pts = pts_r;
    if (bad_r) begin
      ex_stat = 1'b0;
      ex_type = op_sel_r ? `SMCP_ACK_SEL : (op_ret_r ? `SMCP_ACK_RET :
                (op_sto_r ? `SMCP_ACK_STO : `SMCP_ACK_ERR));
    end else if (op_sel_r) begin
      ex_type = `SMCP_ACK_SEL;
      if (selm_r == `SMCP_SELM_STORE || selm_r == `SMCP_SELM_RETR) begin
        ex_stat = 1'b1;
        ex_sst = S_STOP;
        ex_pts = 33'h0;
      end else begin
        ex_sst = S_NONE;
      end
    end else if (op_ret_r) begin
      ex_type = `SMCP_ACK_RET;
      if (sst_r != S_NONE && mode_r == `SMCP_SELM_RETR) begin
        case (req_r)
          5'h10: begin
            if (sst_r == S_STOP && !inf_r) begin
              ex_stat = 1'b1;
              ex_pts = dir_r ? pts_r + tcv_r : pts_r - tcv_r;
            end
          end
          5'h08: begin
            ex_stat = 1'b1;
            ex_sst = S_PLAY;
          end
          5'h04: begin
            if (sst_r == S_PLAY) begin
              ex_stat = 1'b1;
              ex_sst = S_PAUSE;
            end
          end
          5'h02: begin
            if (sst_r == S_PAUSE) begin
              ex_stat = 1'b1;
              ex_sst = S_PLAY;
            end
          end
          5'h01: begin
            ex_stat = 1'b1;
            ex_sst = S_STOP;
          end
          default: ex_stat = 1'b0;
        endcase
      end
    end else if (op_sto_r) begin
      ex_type = `SMCP_ACK_STO;
      if (sst_r != S_NONE && mode_r == `SMCP_SELM_STORE) begin
        ex_stat = 1'b1;
        ex_sst = rec_r ? S_REC : S_STOP;
      end
    end else begin
      ex_send = 1'b0;
    end
  end

  // ack word with optional time code
  function [71:0] ack_word;
    input [3:0] typ;
    input stat;
    input [32:0] ts;
    begin
      ack_word = {`SMCP_KIND_ACK, typ, 10'h000, 1'b1, stat,
                  7'h00, 1'b0, 4'h0, ts[32:30], 1'b1, ts[29:15], 1'b1,
                  ts[14:0], 1'b1};
    end
  endfunction

  wire [71:0] ex_word = ack_word(ex_type, ex_stat, ex_pts);
  wire [71:0] pd_word = ack_word(pend_type_r, pend_stat_r, pts_r);
  wire ex_long = ex_stat & (ex_type == `SMCP_ACK_RET || ex_type == `SMCP_ACK_STO);
  wire pd_long = pend_stat_r & (pend_type_r != `SMCP_ACK_ERR);
  wire do_exec = (pst_r == P_EXEC) & tx_go;
  wire do_pend = pend_r & tx_go & (pst_r != P_EXEC);
  reg [9:0] pst_nxt;

  // command parser
  always @* begin
    pst_nxt = pst_r;
    if (frame_start_i) begin
      pst_nxt = P_KIND;
    end else if (do_exec) begin
      pst_nxt = P_SKIP;
    end else if (seg_end) begin
      case (pst_r)
        P_KIND: pst_nxt = (sh_nxt[7:0] == `SMCP_KIND_CTRL) ? P_CTRL : P_SKIP;
        P_CTRL: begin
          if (ops == 3'h0)
            pst_nxt = P_SKIP;
          else if ((ops & (ops - 3'h1)) != 3'h0)
            pst_nxt = P_EXEC;
          else
            pst_nxt = ops[2] ? P_SEL : (ops[1] ? P_RET : P_STO);
        end
        P_SEL: pst_nxt = P_EXEC;
        P_RET: begin
          if (reqs == 5'h0)
            pst_nxt = P_SKIP;
          else if ((reqs & (reqs - 5'h1)) != 5'h0)
            pst_nxt = P_EXEC;
          else
            pst_nxt = (reqs[4] | reqs[3]) ? P_OPT : P_EXEC;
        end
        P_OPT: pst_nxt = P_TCH;
        P_STO: begin
          if (sh_nxt[1:0] == 2'h0)
            pst_nxt = P_SKIP;
          else
            pst_nxt = (sh_nxt[1:0] == 2'h2) ? P_TCH : P_EXEC;
        end
        P_TCH: pst_nxt = sh_nxt[0] ? P_EXEC : P_TCB;
        P_TCB: pst_nxt = P_EXEC;
        default: pst_nxt = P_SKIP;
      endcase
    end
  end

  reg [5:0] cnt_nxt;
  always @* begin
    case (pst_nxt)
      P_KIND: cnt_nxt = `SMCP_LEN_KIND;
      P_CTRL: cnt_nxt = `SMCP_LEN_CTRL;
      P_SEL: cnt_nxt = `SMCP_LEN_SEL;
      P_RET: cnt_nxt = `SMCP_LEN_RET;
      P_OPT: cnt_nxt = `SMCP_LEN_OPT;
      P_STO: cnt_nxt = `SMCP_LEN_STO;
      P_TCH: cnt_nxt = `SMCP_LEN_TCH;
      P_TCB: cnt_nxt = `SMCP_LEN_TCB;
      default: cnt_nxt = 6'd0;
    endcase
  end

  always @(posedge clock_i) begin
    if (!nrst_i) begin
      pst_r <= P_SKIP;
      cnt_r <= 6'd0;
      sh_r <= 40'h0;
      op_sel_r <= 1'b0;
      op_ret_r <= 1'b0;
      op_sto_r <= 1'b0;
      req_r <= 5'h0;
      rec_r <= 1'b0;
      halt_r <= 1'b0;
      bad_r <= 1'b0;
      dir_r <= 1'b1;
      speed_r <= 1'b1;
      inf_r <= 1'b1;
      tcv_r <= 33'h0;
      id_r <= 32'h0;
      selm_r <= 5'h0;
      cmd_ready_o <= 1'b0;
    end else begin
      pst_r <= pst_nxt;
      cmd_ready_o <= ctrl_r[`SMCP_CTRL_PARSE_EN] & (pst_nxt != P_EXEC) & (pst_nxt != P_SKIP);
      if (frame_start_i || (seg_end && pst_nxt != pst_r)) begin
        cnt_r <= frame_start_i ? `SMCP_LEN_KIND : cnt_nxt;
      end else if (take) begin
        cnt_r <= cnt_r - 6'd1;
      end
      if (take)
        sh_r <= sh_nxt;
      if (frame_start_i) begin
        op_sel_r <= 1'b0;
        op_ret_r <= 1'b0;
        op_sto_r <= 1'b0;
        req_r <= 5'h0;
        bad_r <= 1'b0;
        inf_r <= 1'b1;
        dir_r <= 1'b1;
        speed_r <= 1'b1;
        tcv_r <= 33'h0;
      end else if (seg_end) begin
        case (pst_r)
          P_CTRL: begin
            op_sel_r <= sh_nxt[15];
            op_ret_r <= sh_nxt[14];
            op_sto_r <= sh_nxt[13];
            bad_r <= !sh_nxt[0] | ((ops & (ops - 3'h1)) != 3'h0);
          end
          P_SEL: begin
            id_r <= {sh_nxt[39:25], sh_nxt[23:9], sh_nxt[7:6]};
            selm_r <= sh_nxt[5:1];
            bad_r <= bad_r | !sh_nxt[24] | !sh_nxt[8] | !sh_nxt[0];
          end
          P_RET: begin
            req_r <= reqs;
            bad_r <= bad_r | !sh_nxt[0] | ((reqs & (reqs - 5'h1)) != 5'h0);
          end
          P_OPT: begin
            dir_r <= req_r[4] ? sh_nxt[0] : sh_nxt[6];
            speed_r <= req_r[4] ? 1'b1 : sh_nxt[7];
          end
          P_STO: begin
            rec_r <= sh_nxt[1];
            halt_r <= sh_nxt[0];
            bad_r <= bad_r | (sh_nxt[1:0] == 2'h3);
          end
          P_TCH: inf_r <= sh_nxt[0];
          P_TCB: begin
            tcv_r <= {sh_nxt[35:33], sh_nxt[31:17], sh_nxt[15:1]};
            bad_r <= bad_r | !sh_nxt[32] | !sh_nxt[16] | !sh_nxt[0];
          end
          default: bad_r <= bad_r;
        endcase
      end
    end
  end

  always @(posedge clock_i) begin
    if (!nrst_i) begin
      tick_cnt_r <= 9'd0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TICK_CYC - 1);
      tick_cnt_r <= (tick_cnt_r == TICK_CYC - 1) ? 9'd0 : tick_cnt_r + 9'd1;
    end
  end

  wire [32:0] step = run_fast_r ? `SMCP_FAST_STEP : 33'd1;
  wire running = (sst_r == S_PLAY) | (sst_r == S_REC);

  // stream state and playback pointer
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      sst_r <= S_NONE;
      mode_r <= 5'h0;
      stream_number_r <= 32'h0;
      pts_r <= 33'h0;
      remain_r <= 33'h0;
      run_inf_r <= 1'b1;
      run_dir_r <= 1'b1;
      run_fast_r <= 1'b0;
      pend_r <= 1'b0;
      pend_type_r <= `SMCP_ACK_ERR;
      pend_stat_r <= 1'b0;
    end else if (do_exec) begin
      sst_r <= ex_sst;
      pts_r <= ex_pts;
      if (op_sel_r && !bad_r) begin
        stream_number_r <= id_r;
        mode_r <= ex_stat ? selm_r : 5'h0;
      end
      if (ex_stat && ex_sst != sst_r) begin
        pend_r <= 1'b0;
        run_dir_r <= (req_r == 5'h02) ? 1'b1 : dir_r;
        run_fast_r <= (req_r == 5'h08) ? !speed_r : 1'b0;
        run_inf_r <= (req_r == 5'h02) ? 1'b1 : inf_r;
        remain_r <= tcv_r;
      end
    end else begin
      if (do_pend)
        pend_r <= 1'b0;
      if (tick_r && running) begin
        if (sst_r == S_PLAY && !run_dir_r && pts_r < step) begin
          // start of stream reached backward
          sst_r <= S_STOP;
          pend_r <= 1'b1;
          pend_type_r <= `SMCP_ACK_ERR;
          pend_stat_r <= 1'b0;
        end else if (!run_inf_r && remain_r <= step) begin
          sst_r <= S_STOP;
          pts_r <= run_dir_r ? pts_r + step : pts_r - step;
          pend_r <= 1'b1;
          pend_type_r <= (sst_r == S_REC) ? `SMCP_ACK_STO : `SMCP_ACK_RET;
          pend_stat_r <= 1'b1;
        end else begin
          pts_r <= run_dir_r ? pts_r + step : pts_r - step;
          remain_r <= remain_r - step;
        end
      end
    end
  end

  // acknowledgement transmitter
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      tx_sh_r <= 72'h0;
      tx_len_r <= 7'd0;
      ack_bit_o <= 1'b0;
      ack_valid_o <= 1'b0;
      ack_last_o <= 1'b0;
      last_stat_r <= 1'b0;
      last_type_r <= 4'h0;
      n_acc_r <= 16'h0;
      n_rej_r <= 16'h0;
    end else if (do_exec && ex_send) begin
      tx_sh_r <= {ex_word[70:0], 1'b0};
      tx_len_r <= ex_long ? `SMCP_ACK_BITS : `SMCP_ACK_BITS_SHORT;
      ack_bit_o <= ex_word[71];
      ack_valid_o <= 1'b1;
      ack_last_o <= 1'b0;
      last_stat_r <= ex_stat;
      last_type_r <= ex_type;
      n_acc_r <= n_acc_r + {15'h0, ex_stat};
      n_rej_r <= n_rej_r + {15'h0, !ex_stat};
    end else if (do_pend) begin
      tx_sh_r <= {pd_word[70:0], 1'b0};
      tx_len_r <= pd_long ? `SMCP_ACK_BITS : `SMCP_ACK_BITS_SHORT;
      ack_bit_o <= pd_word[71];
      ack_valid_o <= 1'b1;
      ack_last_o <= 1'b0;
      last_stat_r <= pend_stat_r;
      last_type_r <= pend_type_r;
    end else if (ack_valid_o && ack_ready_i) begin
      tx_sh_r <= {tx_sh_r[70:0], 1'b0};
      tx_len_r <= tx_len_r - 7'd1;
      ack_bit_o <= tx_sh_r[71];
      ack_valid_o <= (tx_len_r != 7'd1);
      ack_last_o <= (tx_len_r == 7'd2);
    end
  end

  // wishbone slave
  wire wb_req = wb_cyc_i & wb_stb_i & !wb_ack_o;
  reg [31:0] rd_data;
  always @* begin
    case (wb_adr_i)
      `SMCP_REG_CTRL: rd_data = {30'h0, ctrl_r};
      `SMCP_REG_STATUS: rd_data = {11'h0, mode_r, 4'h0, last_type_r,
                                   last_stat_r, !tx_idle, pend_r, sst_r};
      `SMCP_REG_STREAM: rd_data = stream_number_r;
      `SMCP_REG_PTS_LO: rd_data = pts_r[31:0];
      `SMCP_REG_PTS_HI: rd_data = {31'h0, pts_r[32]};
      `SMCP_REG_REMAIN: rd_data = remain_r[31:0];
      `SMCP_REG_COUNT: rd_data = {n_rej_r, n_acc_r};
      default: rd_data = 32'h0;
    endcase
  end

  always @(posedge clock_i) begin
    if (!nrst_i) begin
      ctrl_r <= `SMCP_CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= wb_we_i ? 32'h0 : rd_data;
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == `SMCP_REG_CTRL)
          ctrl_r <= wb_dat_i[1:0];
      end
    end
  end

endmodule
`default_nettype wire
